// ===== common/pitu_pkg.sv
// preset interval timer unit: register map, field layout, modes, tick timing
// assumes a 10 MHz pclk and an APB master with 32-bit data
//
// Functional notes
// - one 16-bit word per timer holds state
// - timer index space covers 256 timers
// - in run, decrement per tick until zero
// - low twelve bits: three packed decimal digits
// - tick-base code sits in bits 12-13
// - base codes: 10ms, 100ms, 1s, 10s
// - durations above 2h46m30s are rejected
// - smallest fitting base, count truncated down
// - base ranges up to 9.99s/99.9s/999s/9990s
// - start loads preset into the timer word
// - remaining count readable binary and decimal
// - remaining equals preset minus elapsed ticks
// - start only on rising start edge outside off-delay
// - pulse: status high while running only
// - pulse: reset edge while running clears timer
// - stretched: full run, status high throughout
// - stretched: new start edge restarts countdown
// - stretched: reset edge while running clears count and base
// - on-delay: status after expiry while start high
// - latched: status on expiry regardless of start
// - off-delay: start on fall, status start|running
// - on-delay: reset level idle with start clears
// - latched: start edge while running restarts
// - latched: reset edge clears, status low
// - off-delay: start rise while running resets, waits next fall
package pitu_pkg;
	localparam int NUM_TIMERS = 4;
	localparam int IDX_SPACE = 256;
	// timer word layout
	localparam int CNT_LSB = 0;
	localparam int CNT_MSB = 11;
	localparam int BASE_LSB = 12;
	localparam int BASE_MSB = 13;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [9:0] CNT_MAX = 10'h3E7;
	// duration input is in 10 ms units; 999000 units is 9990 s
	localparam logic [19:0] DUR_MAX = 20'hF3E58;
	localparam logic [19:0] DUR_LIM0 = 20'h003E7;
	localparam logic [19:0] DUR_LIM1 = 20'h0270F;
	localparam logic [19:0] DUR_LIM2 = 20'h1869F;
	// address map: bit 12 picks global page, bits 11:4 the timer index
	localparam int ADDR_W = 13;
	localparam int GLOB_BIT = 12;
	localparam logic [1:0] REG_PRESET = 2'h0;
	localparam logic [1:0] REG_CTRL = 2'h1;
	localparam logic [1:0] REG_WORD = 2'h2;
	localparam logic [1:0] REG_BIN = 2'h3;
	localparam logic [1:0] REG_RUN = 2'h0;
	localparam logic [1:0] REG_DUR = 2'h1;
	localparam logic [1:0] REG_STAT = 2'h2;
	// control and status field positions
	localparam int CTRL_START = 0;
	localparam int CTRL_RESET = 1;
	localparam int CTRL_MODE_LSB = 2;
	localparam int CTRL_MODE_MSB = 4;
	localparam int BIN_STATUS = 16;
	localparam int BIN_RUNNING = 17;
	localparam int DUR_IDX_LSB = 24;
	localparam int DUR_MSB = 19;
	// tick timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int TICK_10MS_NS = 10000000;
	localparam int TICK_10MS_CYCLES = TICK_10MS_NS / CLK_PERIOD_NS;
	localparam int TICK_CNT_W = 17;
	localparam logic [3:0] DECADE_LAST = 4'h9;
	typedef enum logic [2:0] {
		PITU_MODE_PULSE = 3'b000,
		PITU_MODE_STRETCH = 3'b001,
		PITU_MODE_ON_DELAY = 3'b010,
		PITU_MODE_LATCHED = 3'b011,
		PITU_MODE_OFF_DELAY = 3'b100
	} pitu_mode_t;
endpackage

// ===== hw/pitu_top.sv
// preset interval timer unit: timer bank, tick dividers and APB slave
// assumes the controller logic drives start/reset levels through registers
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module pitu_top #(
	parameter int unsigned TICK_CYCLES = pitu_pkg::TICK_10MS_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pitu_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [pitu_pkg::NUM_TIMERS-1:0] timer_status
);
	localparam int N = pitu_pkg::NUM_TIMERS;

	typedef struct packed {
		logic [N-1:0][15:0] preset;
		logic [N-1:0][15:0] word;
		pitu_pkg::pitu_mode_t [N-1:0] mode;
		logic [N-1:0] start_lvl;
		logic [N-1:0] reset_lvl;
		logic [N-1:0] start_prev;
		logic [N-1:0] reset_prev;
		logic [N-1:0] running;
		logic [N-1:0] status;
		logic run;
		logic reject;
		logic [pitu_pkg::TICK_CNT_W-1:0] tick_cnt;
		logic [3:0] div100;
		logic [3:0] div1s;
		logic [3:0] div10s;
		logic [3:0] strobe;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} pitu_state_t;

	pitu_state_t state_reg;
	pitu_state_t state_next;

	// one decimal step down; callers only pass a nonzero count
	function automatic logic [11:0] bcd_dec(input logic [11:0] c);
		logic [11:0] r;
		r = c;
		if (c[3:0] != 4'h0) begin
			r[3:0] = c[3:0] - 4'h1;
		end else begin
			r[3:0] = pitu_pkg::DECADE_LAST;
			if (c[7:4] != 4'h0) begin
				r[7:4] = c[7:4] - 4'h1;
			end else begin
				r[7:4] = pitu_pkg::DECADE_LAST;
				r[11:8] = c[11:8] - 4'h1;
			end
		end
		return r;
	endfunction

	function automatic logic [9:0] bcd_to_bin(input logic [11:0] c);
		return 10'(c[11:8] * 7'd100) + 10'(c[7:4] * 4'd10) + 10'(c[3:0]);
	endfunction

	function automatic logic [11:0] bin_to_bcd(input logic [9:0] v);
		return {4'(v / 10'd100), 4'((v / 10'd10) % 10'd10), 4'(v % 10'd10)};
	endfunction

	// smallest base that holds the duration, count truncated down
	function automatic logic [15:0] dur_to_word(input logic [19:0] d);
		logic [1:0] b;
		logic [19:0] q;
		b = 2'h0;
		q = d;
		if (d > pitu_pkg::DUR_LIM2) begin
			b = 2'h3;
			q = d / 20'd1000;
		end else if (d > pitu_pkg::DUR_LIM1) begin
			b = 2'h2;
			q = d / 20'd100;
		end else if (d > pitu_pkg::DUR_LIM0) begin
			b = 2'h1;
			q = d / 20'd10;
		end
		return {2'h0, b, bin_to_bcd(q[9:0])};
	endfunction

	logic s_rise, s_fall, r_rise, tk, expired, stv, rstv, glob, wr, rd;
	logic [7:0] tidx;
	logic [1:0] rsel;
	logic [31:0] rdat;
	logic [19:0] dur;

	// next-state logic for dividers, timers and the bus slave
	always_comb begin
		s_rise = 1'b0;
		s_fall = 1'b0;
		r_rise = 1'b0;
		tk = 1'b0;
		expired = 1'b0;
		stv = 1'b0;
		rstv = 1'b0;
		state_next = state_reg;
		glob = paddr[pitu_pkg::GLOB_BIT];
		tidx = paddr[11:4];
		rsel = paddr[3:2];
		// writes land only in the access cycle that completes
		wr = psel & penable & state_reg.pready & pwrite;
		rd = psel & ~penable;
		rdat = 32'h0000_0000;
		dur = pwdata[pitu_pkg::DUR_MSB:0];

		// 10 ms prescaler then three decade stages
		state_next.strobe = 4'h0;
		if (state_reg.tick_cnt == pitu_pkg::TICK_CNT_W'(TICK_CYCLES - 1)) begin
			state_next.tick_cnt = '0;
			state_next.strobe[0] = 1'b1;
			state_next.div100 = state_reg.div100 + 4'h1;
			if (state_reg.div100 == pitu_pkg::DECADE_LAST) begin
				state_next.div100 = 4'h0;
				state_next.strobe[1] = 1'b1;
				state_next.div1s = state_reg.div1s + 4'h1;
				if (state_reg.div1s == pitu_pkg::DECADE_LAST) begin
					state_next.div1s = 4'h0;
					state_next.strobe[2] = 1'b1;
					state_next.div10s = state_reg.div10s + 4'h1;
					if (state_reg.div10s == pitu_pkg::DECADE_LAST) begin
						state_next.div10s = 4'h0;
						state_next.strobe[3] = 1'b1;
					end
				end
			end
		end else begin
			state_next.tick_cnt = state_reg.tick_cnt + pitu_pkg::TICK_CNT_W'(1);
		end

		for (int i = 0; i < N; i++) begin
			stv = state_reg.start_lvl[i];
			rstv = state_reg.reset_lvl[i];
			// edge detect against last cycle's level; both come from registers
			s_rise = stv & ~state_reg.start_prev[i];
			s_fall = ~stv & state_reg.start_prev[i];
			r_rise = rstv & ~state_reg.reset_prev[i];
			state_next.start_prev[i] = stv;
			state_next.reset_prev[i] = rstv;
			// strobe picked by the word's base, gated by run
			tk = state_reg.run & state_reg.strobe[state_reg.word[i][13:12]]
				& state_reg.running[i] & (state_reg.word[i][11:0] != 12'h000);
			expired = tk & (state_reg.word[i][11:0] == 12'h001);
			// each tick removes exactly one unit
			if (tk) begin
				state_next.word[i][11:0] = bcd_dec(state_reg.word[i][11:0]);
			end
			state_next.running[i] = state_reg.running[i] & ~expired;
			case (state_reg.mode[i])
				pitu_pkg::PITU_MODE_STRETCH: begin
					if (r_rise & state_reg.running[i]) begin
						state_next.word[i] = pitu_pkg::WORD_RST;
						state_next.running[i] = 1'b0;
					end else if (s_rise) begin
						state_next.word[i] = state_reg.preset[i];
						state_next.running[i] = state_reg.preset[i][11:0] != 12'h000;
					end
					state_next.status[i] = state_next.running[i];
				end
				pitu_pkg::PITU_MODE_ON_DELAY: begin
					// idle reset level with start high also clears
					if ((r_rise & state_reg.running[i]) | (rstv & ~state_reg.running[i] & stv)) begin
						state_next.word[i] = pitu_pkg::WORD_RST;
						state_next.running[i] = 1'b0;
						state_next.status[i] = 1'b0;
					end else if (s_rise) begin
						state_next.word[i] = state_reg.preset[i];
						state_next.running[i] = state_reg.preset[i][11:0] != 12'h000;
						state_next.status[i] = state_reg.preset[i][11:0] == 12'h000;
					end else if (!stv) begin
						state_next.running[i] = 1'b0;
						state_next.status[i] = 1'b0;
					end else if (expired) begin
						state_next.status[i] = 1'b1;
					end
				end
				pitu_pkg::PITU_MODE_LATCHED: begin
					if (r_rise) begin
						state_next.word[i] = pitu_pkg::WORD_RST;
						state_next.running[i] = 1'b0;
						state_next.status[i] = 1'b0;
					end else if (s_rise) begin
						state_next.word[i] = state_reg.preset[i];
						state_next.running[i] = state_reg.preset[i][11:0] != 12'h000;
					end else if (expired) begin
						state_next.status[i] = 1'b1;
					end
				end
				pitu_pkg::PITU_MODE_OFF_DELAY: begin
					if (r_rise & state_reg.running[i]) begin
						state_next.word[i] = pitu_pkg::WORD_RST;
						state_next.running[i] = 1'b0;
					// rise while running stops, waits for next fall
					end else if (s_rise & state_reg.running[i]) begin
						state_next.word[i] = pitu_pkg::WORD_RST;
						state_next.running[i] = 1'b0;
					end else if (s_fall) begin
						state_next.word[i] = state_reg.preset[i];
						state_next.running[i] = state_reg.preset[i][11:0] != 12'h000;
					end
					state_next.status[i] = stv | state_next.running[i];
				end
				default: begin
					// pulse reset edge only counts while running
					if (r_rise & state_reg.running[i]) begin
						state_next.word[i] = pitu_pkg::WORD_RST;
						state_next.running[i] = 1'b0;
					// only a rising start starts the timer
					end else if (s_rise) begin
						state_next.word[i] = state_reg.preset[i];
						state_next.running[i] = state_reg.preset[i][11:0] != 12'h000;
					end else if (!stv) begin
						state_next.running[i] = 1'b0;
					end
					state_next.status[i] = state_next.running[i];
				end
			endcase

			// software writes to this timer; level changes act next cycle
			if (wr && !glob && tidx == 8'(i)) begin
				if (rsel == pitu_pkg::REG_PRESET) begin
					// raw word taken as base digit over three count digits
					state_next.preset[i] = pwdata[15:0];
				end else if (rsel == pitu_pkg::REG_CTRL) begin
					state_next.start_lvl[i] = pwdata[pitu_pkg::CTRL_START];
					state_next.reset_lvl[i] = pwdata[pitu_pkg::CTRL_RESET];
					state_next.mode[i] = pitu_pkg::pitu_mode_t'(
						pwdata[pitu_pkg::CTRL_MODE_MSB:pitu_pkg::CTRL_MODE_LSB]);
				end
			end
			// duration write; too long leaves the preset alone
			if (wr && glob && rsel == pitu_pkg::REG_DUR
				&& pwdata[31:pitu_pkg::DUR_IDX_LSB] == 8'(i) && dur <= pitu_pkg::DUR_MAX) begin
				state_next.preset[i] = dur_to_word(dur);
			end

			// read back: preset, control and both forms of the remaining count
			if (!glob && tidx == 8'(i)) begin
				case (rsel)
					pitu_pkg::REG_PRESET: rdat = {16'h0000, state_reg.preset[i]};
					pitu_pkg::REG_CTRL: rdat = {27'h0, state_reg.mode[i],
						state_reg.reset_lvl[i], state_reg.start_lvl[i]};
					pitu_pkg::REG_WORD: rdat = {16'h0000, state_reg.word[i]};
					default: rdat = {14'h0, state_reg.running[i], state_reg.status[i],
						6'h00, bcd_to_bin(state_reg.word[i][11:0])};
				endcase
			end
		end

		// global page: run level, duration entry, reject flag
		if (wr && glob && rsel == pitu_pkg::REG_RUN) begin
			state_next.run = pwdata[0];
		end
		if (wr && glob && rsel == pitu_pkg::REG_STAT && pwdata[0]) begin
			state_next.reject = 1'b0;
		end
		// set after clear so a reject in the clearing cycle survives
		if (wr && glob && rsel == pitu_pkg::REG_DUR && dur > pitu_pkg::DUR_MAX) begin
			state_next.reject = 1'b1;
		end
		if (glob) begin
			case (rsel)
				pitu_pkg::REG_RUN: rdat = {31'h0, state_reg.run};
				pitu_pkg::REG_STAT: rdat = {31'h0, state_reg.reject};
				default: rdat = 32'h0000_0000;
			endcase
		end

		// any index below 256 is legal; absent timers read zero
		state_next.pready = rd;
		state_next.pslverr = rd & glob & (rsel == 2'h3);
		state_next.prdata = (rd && !pwrite) ? rdat : 32'h0000_0000;
	end

	// single state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign prdata = state_reg.prdata;
	assign pready = state_reg.pready;
	assign pslverr = state_reg.pslverr;
	assign timer_status = state_reg.status;

	// checks on timers 0 to 2 and the bus; each mode except latched is watched on the timer the bench uses for it
	property p_pulse_status;
		@(posedge pclk) disable iff (!presetn)
		(state_reg.mode[0] == pitu_pkg::PITU_MODE_PULSE && $past(state_reg.mode[0])
			== pitu_pkg::PITU_MODE_PULSE) |-> state_reg.status[0] == state_reg.running[0];
	endproperty
	a_pulse_status: assert property (p_pulse_status) else $error("pulse status off run");

	property p_tick_dec;
		@(posedge pclk) disable iff (!presetn)
		(state_reg.run && state_reg.strobe[state_reg.word[0][13:12]] && state_reg.running[0]
			&& state_reg.word[0][11:0] != 12'h000
			&& state_reg.start_lvl[0] == state_reg.start_prev[0]
			&& state_reg.reset_lvl[0] == state_reg.reset_prev[0])
		|=> bcd_to_bin(state_reg.word[0][11:0]) + 10'd1 == bcd_to_bin($past(state_reg.word[0][11:0]));
	endproperty
	a_tick_dec: assert property (p_tick_dec) else $error("tick did not remove one unit");

	property p_no_level_start;
		@(posedge pclk) disable iff (!presetn)
		(!state_reg.running[0] && state_reg.start_lvl[0] && state_reg.start_prev[0]
			&& state_reg.mode[0] != pitu_pkg::PITU_MODE_OFF_DELAY) |=> !state_reg.running[0];
	endproperty
	a_no_level_start: assert property (p_no_level_start) else $error("held start began run");

	property p_pulse_reset;
		@(posedge pclk) disable iff (!presetn)
		(state_reg.mode[0] == pitu_pkg::PITU_MODE_PULSE && state_reg.running[0]
			&& state_reg.reset_lvl[0] && !state_reg.reset_prev[0])
		|=> state_reg.word[0] == 16'h0000 && !state_reg.running[0] && !state_reg.status[0];
	endproperty
	a_pulse_reset: assert property (p_pulse_reset) else $error("pulse reset not cleared");

	property p_stretch_reset;
		@(posedge pclk) disable iff (!presetn)
		(state_reg.mode[1] == pitu_pkg::PITU_MODE_STRETCH && state_reg.running[1]
			&& state_reg.reset_lvl[1] && !state_reg.reset_prev[1])
		|=> state_reg.word[1] == 16'h0000 && !state_reg.status[1];
	endproperty
	a_stretch_reset: assert property (p_stretch_reset) else $error("stretch reset failed");

	property p_on_delay_start;
		@(posedge pclk) disable iff (!presetn)
		(state_reg.mode[2] == pitu_pkg::PITU_MODE_ON_DELAY && state_reg.status[2])
		|-> state_reg.start_prev[2];
	endproperty
	a_on_delay_start: assert property (p_on_delay_start) else $error("on-delay status w/o start");

	property p_off_delay_status;
		@(posedge pclk) disable iff (!presetn)
		(state_reg.mode[0] == pitu_pkg::PITU_MODE_OFF_DELAY
			&& $past(state_reg.mode[0]) == pitu_pkg::PITU_MODE_OFF_DELAY)
		|-> state_reg.status[0] == (state_reg.start_prev[0] | state_reg.running[0]);
	endproperty
	a_off_delay_status: assert property (p_off_delay_status) else $error("off-delay status");

	property p_reject;
		@(posedge pclk) disable iff (!presetn)
		(wr && glob && rsel == pitu_pkg::REG_DUR && dur > pitu_pkg::DUR_MAX)
		|=> state_reg.reject && state_reg.preset == $past(state_reg.preset);
	endproperty
	a_reject: assert property (p_reject) else $error("long duration not rejected");

	property p_strobe_nest;
		@(posedge pclk) disable iff (!presetn)
		state_reg.strobe[2] |-> state_reg.strobe[1] && state_reg.strobe[0];
	endproperty
	a_strobe_nest: assert property (p_strobe_nest) else $error("tick strobes not nested");

	property p_apb_ready;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable) |=> pready ##1 !pready || (psel && !penable);
	endproperty
	a_apb_ready: assert property (p_apb_ready) else $error("apb answer late");

	c_pulse_run: cover property (@(posedge pclk) disable iff (!presetn)
		state_reg.mode[0] == pitu_pkg::PITU_MODE_PULSE && $fell(state_reg.running[0]));
	c_on_delay_hit: cover property (@(posedge pclk) disable iff (!presetn)
		state_reg.mode[0] == pitu_pkg::PITU_MODE_ON_DELAY && $rose(state_reg.status[0]));
	c_off_delay_fall: cover property (@(posedge pclk) disable iff (!presetn)
		state_reg.mode[0] == pitu_pkg::PITU_MODE_OFF_DELAY && $rose(state_reg.running[0]));
	c_reject: cover property (@(posedge pclk) disable iff (!presetn) $rose(state_reg.reject));
endmodule // pitu_top

// ===== bench/pitu_ctl_model.sv
// controller model: program logic that reaches the timer unit over its register bus
// assumes callers enter its tasks just after a rising pclk edge
`timescale 1ns/10ps
module pitu_ctl_model (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [pitu_pkg::ADDR_W-1:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// bus idle at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 13'h0000;
		pwdata = 32'h00000000;
	end

	// one transfer: setup, access held until pready, then release
	task automatic xfer(input logic w, input logic [12:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		r = prdata;
		e = pslverr;
		// released lines show the inverse so a stale value never looks valid
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
		@(posedge pclk); // gap so the next setup never lands in this time step
	endtask

	task automatic load_preset(input int t, input logic [1:0] base, input logic [11:0] bcd);
		logic [31:0] r;
		logic e;
		xfer(1'b1, 13'(16 * t), {18'h00000, base, bcd}, r, e);
	endtask
endmodule // pitu_ctl_model

// ===== bench/tb_top.sv
// self-checking bench for the timer unit: register map, durations and the five behaviours
// assumes the controller model as bus master and a prescaler shortened to ten cycles
`timescale 1ns/10ps
`define CHK(got, exp) \
	begin \
		compares++; \
		if ((got) !== (exp)) begin \
			bad_count++; \
			$display("Error at %0t ns: got %h expected %h", $time, got, exp); \
		end \
	end
module tb_top;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [pitu_pkg::ADDR_W-1:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [pitu_pkg::NUM_TIMERS-1:0] timer_status;
	int bad_count;
	int compares;
	int seed;
	int tm;
	int t;
	int dur;
	pitu_pkg::pitu_mode_t md;
	logic [31:0] rv;
	logic [31:0] rv2;
	logic ev;
	int corner [8] = '{0, 999, 1000, 9999, 10000, 99999, 100000, 999000};

	// short prescaler makes the 10 ms tick ten cycles so countdowns finish in a short run
	pitu_top #(.TICK_CYCLES(10)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_status(timer_status));
	pitu_ctl_model u_ctl (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// 10 MHz clock
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// verdict and end of run
	task end_of_test;
		if (bad_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// bus helpers; ctl leaves four cycles for the edge detect and the word update
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic wr(input logic [12:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		u_ctl.xfer(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [12:0] a, output logic [31:0] d);
		logic e;
		u_ctl.xfer(1'b0, a, 32'h00000000, d, e);
	endtask
	task automatic ctl(input logic s, input logic r);
		wr(ra(4), {27'h0000000, md, r, s});
		cyc(4);
	endtask
	function automatic logic [12:0] ra(input int off);
		return 13'(16 * tm + off);
	endfunction

	// expected preset word: smallest base that holds the count, truncated down
	function automatic logic [15:0] exp_word(input int d);
		int b;
		int c;
		b = 0;
		c = d;
		while (c > 999) begin
			b++;
			c = c / 10;
		end
		return {2'b00, 2'(b), 4'(c / 100), 4'(c / 10 % 10), 4'(c % 10)};
	endfunction
	function automatic logic [9:0] bcd_bin(input logic [11:0] w);
		return 10'(w[11:8] * 100 + w[7:4] * 10 + w[3:0]);
	endfunction

	// hang guard: the sequence needs about one thousand cycles
	initial begin
		cyc(20000);
		bad_count++;
		end_of_test();
	end

	// main sequence
	initial begin
		bad_count = 0;
		compares = 0;
		seed = 32'h4D1C8AC7;
		presetn = 1'b0;
		cyc(4);
		presetn <= 1'b1;
		cyc(1);
		// reset values, read-only word, absent timer, unmapped offset
		`CHK(timer_status, 4'h0)
		rd(13'h0000, rv);
		`CHK(rv, 32'h00000000)
		wr(13'h0008, 32'h00003FFF);
		rd(13'h0008, rv);
		`CHK(rv, 32'h00000000)
		wr(13'h0090, 32'h00001234);
		rd(13'h0090, rv);
		`CHK(rv, 32'h00000000)
		u_ctl.xfer(1'b0, 13'h100C, 32'h00000000, rv, ev);
		`CHK(ev, 1'b1)
		u_ctl.xfer(1'b0, 13'h1000, 32'h00000000, rv, ev);
		`CHK(ev, 1'b0)
		// durations: corner values on timer 0, then random ones on random timers
		for (int i = 0; i < 24; i++) begin
			t = (i < 8) ? 0 : {$random(seed)} % 4;
			dur = (i < 8) ? corner[i] : {$random(seed)} % 999001;
			wr(13'h1004, {8'(t), 4'h0, 20'(dur)});
			rd(13'(16 * t), rv);
			`CHK(rv[15:0], exp_word(dur))
		end
		// over-long duration leaves the preset alone and raises the reject flag
		// random entries above may have hit timer 0, so give it a known preset first
		wr(13'h1004, 32'h000F3E58);
		wr(13'h1004, {8'h00, 4'h0, 20'(999001 + {$random(seed)} % 49000)});
		rd(13'h0000, rv);
		`CHK(rv[15:0], 16'h3999)
		rd(13'h1008, rv);
		`CHK(rv[0], 1'b1)
		wr(13'h1008, 32'h00000001);
		rd(13'h1008, rv);
		`CHK(rv[0], 1'b0)
		// pulse on timer 0: countdown, freeze when stopped, early end, reset
		tm = 0;
		md = pitu_pkg::PITU_MODE_PULSE;
		wr(13'h1000, 32'h00000001);
		u_ctl.load_preset(tm, 2'b00, 12'h020);
		ctl(1'b1, 1'b0);
		`CHK(timer_status[tm], 1'b1)
		cyc(50);
		wr(13'h1000, 32'h00000000);
		rd(ra(8), rv);
		rd(ra(12), rv2);
		`CHK(rv2[9:0], bcd_bin(rv[11:0]))
		`CHK(rv2[9:0] >= 10'h00C && rv2[9:0] <= 10'h010, 1'b1)
		`CHK(rv[13:12], 2'b00)
		cyc(40);
		rd(ra(8), rv2);
		`CHK(rv2, rv)
		wr(13'h1000, 32'h00000001);
		ctl(1'b0, 1'b0);
		`CHK(timer_status[tm], 1'b0)
		ctl(1'b1, 1'b0);
		ctl(1'b1, 1'b1);
		rd(ra(8), rv);
		`CHK({timer_status[tm], rv[15:0]}, 17'h00000)
		ctl(1'b1, 1'b0);
		`CHK(timer_status[tm], 1'b0)
		u_ctl.load_preset(tm, 2'b00, 12'h005);
		ctl(1'b0, 1'b0);
		ctl(1'b1, 1'b0);
		cyc(80);
		rd(ra(8), rv);
		`CHK({timer_status[tm], rv[15:0]}, 17'h00000)
		// stretched pulse on timer 1: start drops, retrigger, base load, reset
		tm = 1;
		md = pitu_pkg::PITU_MODE_STRETCH;
		u_ctl.load_preset(tm, 2'b00, 12'h006);
		ctl(1'b1, 1'b0);
		ctl(1'b0, 1'b0);
		cyc(30);
		`CHK(timer_status[tm], 1'b1)
		ctl(1'b1, 1'b0);
		cyc(25);
		`CHK(timer_status[tm], 1'b1)
		u_ctl.load_preset(tm, 2'b01, 12'h009);
		ctl(1'b0, 1'b0);
		ctl(1'b1, 1'b0);
		rd(ra(8), rv);
		`CHK(rv[13:12], 2'b01)
		ctl(1'b1, 1'b1);
		rd(ra(8), rv);
		`CHK({timer_status[tm], rv[15:0]}, 17'h00000)
		// on-delay on timer 2: late status, start fall, idle reset with start high
		tm = 2;
		md = pitu_pkg::PITU_MODE_ON_DELAY;
		u_ctl.load_preset(tm, 2'b00, 12'h005);
		ctl(1'b1, 1'b0);
		cyc(20);
		`CHK(timer_status[tm], 1'b0)
		cyc(50);
		`CHK(timer_status[tm], 1'b1)
		ctl(1'b0, 1'b0);
		`CHK(timer_status[tm], 1'b0)
		ctl(1'b1, 1'b0);
		cyc(70);
		ctl(1'b1, 1'b1);
		`CHK(timer_status[tm], 1'b0)
		// latched on-delay on timer 3: expiry with start low, reset, retrigger
		tm = 3;
		md = pitu_pkg::PITU_MODE_LATCHED;
		u_ctl.load_preset(tm, 2'b00, 12'h004);
		ctl(1'b1, 1'b0);
		ctl(1'b0, 1'b0);
		cyc(60);
		`CHK(timer_status[tm], 1'b1)
		ctl(1'b0, 1'b1);
		`CHK(timer_status[tm], 1'b0)
		ctl(1'b1, 1'b0);
		ctl(1'b0, 1'b0);
		// retrigger well inside the first run, so an early expiry cannot latch status
		cyc(5);
		ctl(1'b1, 1'b0);
		cyc(20);
		`CHK(timer_status[tm], 1'b0)
		cyc(40);
		`CHK(timer_status[tm], 1'b1)
		// off-delay on timer 0: timing from the fall, rise while running clears
		tm = 0;
		md = pitu_pkg::PITU_MODE_OFF_DELAY;
		ctl(1'b0, 1'b0);
		ctl(1'b1, 1'b0);
		`CHK(timer_status[tm], 1'b1)
		ctl(1'b0, 1'b0);
		cyc(25);
		`CHK(timer_status[tm], 1'b1)
		cyc(40);
		`CHK(timer_status[tm], 1'b0)
		ctl(1'b1, 1'b0);
		ctl(1'b0, 1'b0);
		ctl(1'b1, 1'b0);
		rd(ra(8), rv);
		`CHK({timer_status[tm], rv[15:0]}, 17'h10000)
		end_of_test();
	end
endmodule // tb_top
